// File: src/tcs_cfg.svh
// register offsets, field positions, masks, reset values and sync count
// assumes: included by bare name from design files only
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH

// ****************************************************************
// byte offsets
// ****************************************************************
`define TCS_OFF_CTRL_A 5'h00
`define TCS_OFF_READ_REQ 5'h02
`define TCS_OFF_CTRLB_CLR 5'h04
`define TCS_OFF_CTRLB_SET 5'h05
`define TCS_OFF_CTRL_C 5'h06
`define TCS_OFF_DEBUG 5'h08
`define TCS_OFF_EVENT 5'h0a
`define TCS_OFF_IEN_CLR 5'h0c
`define TCS_OFF_IEN_SET 5'h0d
`define TCS_OFF_FLAGS 5'h0e
`define TCS_OFF_STATUS 5'h0f
`define TCS_OFF_COUNT 5'h10
`define TCS_OFF_PERIOD 5'h14
`define TCS_OFF_CC0 5'h18
`define TCS_OFF_CC1_8 5'h19
`define TCS_OFF_CC1_16 5'h1a

// ****************************************************************
// field positions and writable masks
// ****************************************************************
`define TCS_BIT_SOFT_RESET_BIT 0
`define TCS_BIT_ENABLE 1
`define TCS_BIT_MODE 2
`define TCS_BIT_STOP 3
`define TCS_BIT_BUSY 7
`define TCS_FLAG_OVF 0
`define TCS_FLAG_ERR 1
`define TCS_FLAG_SYNC 3
`define TCS_FLAG_MC0 4
`define TCS_FLAG_MC1 5
`define TCS_MASK_CTRL_A 16'h3f6f
`define TCS_MASK_READ_REQ 16'hc01f
`define TCS_MASK_CTRLB 8'hc5
`define TCS_MASK_CTRL_C 8'h33
`define TCS_MASK_DEBUG 8'h01
`define TCS_MASK_EVENT 16'h3137
`define TCS_MASK_FLAGS 8'h3b
`define TCS_MODE_16 2'h0
`define TCS_MODE_8 2'h1

// ****************************************************************
// reset values and sync timing
// ****************************************************************
`define TCS_RST_BYTE 8'h00
`define TCS_RST_HALF 16'h0000
`define TCS_SYNC_EDGES 2'h2

`endif

// File: src/tcs_pkg.sv
// types shared by the timer register sync bank
// assumes: compiled before the design modules
package tcs_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WSYNC = 3'b010,
        ST_RSYNC = 3'b100
    } tcs_state_type;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2
    } tcs_size_type;
endpackage : tcs_pkg

// File: src/tcs_edge_sync.sv
// two-flop synchroniser with rising-edge detect for the counter clock pin
// assumes: i_async is unrelated to i_clock and slower than half its rate
`timescale 1ns/1ns
module tcs_edge_sync (
    input wire logic i_clock,  // bus clock
    input wire logic i_reset,  // synchronous, active high
    input wire logic i_async,  // asynchronous level
    output logic o_rise        // one-cycle pulse per rising edge
);
    logic meta_q, meta_d, sync_q, sync_d, last_q, last_d;

    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
        last_d = sync_q;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            last_q <= last_d;
        end
    end

    // edge taken between second and third stage, never from meta_q
    assign o_rise = sync_q & ~last_q;
endmodule : tcs_edge_sync

// File: src/tcs_bank.sv
// register bank of the timer with access synchronisation to the counter clock
// assumes: bus master holds a request until o_ready pulses, then drops or changes it
`timescale 1ns/1ns
`include "tcs_cfg.svh"
module tcs_bank import tcs_pkg::*; (
    input wire logic i_clock,              // bus clock, 250 MHz
    input wire logic i_reset,              // synchronous, active high
    input wire logic i_counter_clock,      // counter clock pin, asynchronous
    input wire logic i_sel,                // request valid
    input wire logic i_write,              // 1 write, 0 read
    input wire logic [4:0] i_addr,         // byte address
    input wire tcs_size_type i_size,       // access width
    input wire logic [31:0] i_wdata,       // write data, lane 0 at i_addr
    input wire logic [3:0] i_timer_events, // pulses: mc1, mc0, err, ovf
    output logic o_ready,                  // one-cycle completion pulse
    output logic [31:0] o_rdata,           // read data, valid with o_ready
    output logic o_irq,                    // interrupt request level
    output logic o_sync_pending,           // sync in progress
    output logic o_enable                  // timer enable, counter side
);
    // ****************************************************************
    // state
    // ****************************************************************
    logic [15:0] ctrl_a_q, ctrl_a_d, rreq_q, rreq_d, event_q, event_d;
    logic [15:0] count_q, count_d, cc0_q, cc0_d, cc1_q, cc1_d;
    logic [7:0] ctrlb_q, ctrlb_d, control_c_q, control_c_d, debug_q, debug_d;
    logic [7:0] inten_q, inten_d, flags_q, flags_d, period_q, period_d;
    tcs_state_type state_q, state_d;
    logic [1:0] edge_cnt_q, edge_cnt_d;
    logic [4:0] pend_addr_q, pend_addr_d;
    tcs_size_type pend_size_q, pend_size_d;
    logic [31:0] pend_wdata_q, pend_wdata_d, rdata_q, rdata_d;
    logic ready_q, ready_d, irq_q, irq_d, busy_q, busy_d;

    logic cnt_rise, mode8, enabled, needs_sync, take, done, soft_rst;
    logic [7:0] img [32];
    logic [31:0] rd_now, rd_pend;

    tcs_edge_sync u_counter_edge (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_async(i_counter_clock),
        .o_rise(cnt_rise)
    );

    // ****************************************************************
    // lane helpers
    // ****************************************************************
    function automatic logic lane_hit(logic [4:0] k, logic [4:0] a, tcs_size_type s);
        logic [4:0] off;
        off = 5'(k - a);
        unique case (s)
            SZ_BYTE: lane_hit = (k == a);
            SZ_HALF: lane_hit = (k >= a) && (off < 5'h02);
            default: lane_hit = (k >= a) && (off < 5'h04);
        endcase
    endfunction : lane_hit

    function automatic logic [7:0] lane_byte(logic [4:0] k, logic [4:0] a, logic [31:0] w);
        logic [4:0] off;
        off = 5'(k - a);
        lane_byte = w[8*off[1:0] +: 8];
    endfunction : lane_byte

    // bytes that go through the counter domain in the current width mode
    function automatic logic sync_byte(logic [4:0] k, logic m8, logic wr);
        unique case (k)
            `TCS_OFF_CTRL_A: sync_byte = wr;
            `TCS_OFF_CTRLB_CLR, `TCS_OFF_CTRLB_SET, `TCS_OFF_CTRL_C: sync_byte = 1'b1;
            `TCS_OFF_COUNT, `TCS_OFF_CC0, `TCS_OFF_CC1_8: sync_byte = 1'b1;
            `TCS_OFF_COUNT + 5'h01: sync_byte = !m8;
            `TCS_OFF_PERIOD: sync_byte = m8;
            `TCS_OFF_CC1_16, `TCS_OFF_CC1_16 + 5'h01: sync_byte = !m8;
            default: sync_byte = 1'b0;
        endcase
    endfunction : sync_byte

    // ****************************************************************
    // read image and access decode
    // ****************************************************************
    assign mode8 = (ctrl_a_q[`TCS_BIT_MODE +: 2] == `TCS_MODE_8);
    assign enabled = ctrl_a_q[`TCS_BIT_ENABLE];

    always_comb begin
        for (int k = 0; k < 32; k++) begin
            img[k] = 8'h00;
        end
        img[`TCS_OFF_CTRL_A] = ctrl_a_q[7:0];
        img[`TCS_OFF_CTRL_A + 5'h01] = ctrl_a_q[15:8];
        img[`TCS_OFF_READ_REQ] = rreq_q[7:0];
        img[`TCS_OFF_READ_REQ + 5'h01] = rreq_q[15:8];
        img[`TCS_OFF_CTRLB_CLR] = ctrlb_q;
        img[`TCS_OFF_CTRLB_SET] = ctrlb_q;
        img[`TCS_OFF_CTRL_C] = control_c_q;
        img[`TCS_OFF_DEBUG] = debug_q;
        img[`TCS_OFF_EVENT] = event_q[7:0];
        img[`TCS_OFF_EVENT + 5'h01] = event_q[15:8];
        img[`TCS_OFF_IEN_CLR] = inten_q;
        img[`TCS_OFF_IEN_SET] = inten_q;
        img[`TCS_OFF_FLAGS] = flags_q;
        img[`TCS_OFF_STATUS] = 8'h00;
        img[`TCS_OFF_STATUS][`TCS_BIT_BUSY] = busy_q;
        img[`TCS_OFF_STATUS][`TCS_BIT_STOP] = !enabled;
        img[`TCS_OFF_COUNT] = count_q[7:0];
        img[`TCS_OFF_CC0] = cc0_q[7:0];
        if (mode8) begin
            img[`TCS_OFF_PERIOD] = period_q;
            img[`TCS_OFF_CC1_8] = cc1_q[7:0];
        end else begin
            img[`TCS_OFF_COUNT + 5'h01] = count_q[15:8];
            img[`TCS_OFF_CC0 + 5'h01] = cc0_q[15:8];
            img[`TCS_OFF_CC1_16] = cc1_q[7:0];
            img[`TCS_OFF_CC1_16 + 5'h01] = cc1_q[15:8];
        end
    end

    always_comb begin
        rd_now = 32'h0000_0000;
        rd_pend = 32'h0000_0000;
        needs_sync = 1'b0;
        for (int k = 0; k < 32; k++) begin
            if (lane_hit(5'(k), i_addr, i_size)) begin
                rd_now[8*(5'(k - i_addr) & 5'h03) +: 8] = img[k];
                needs_sync = needs_sync | sync_byte(5'(k), mode8, i_write);
            end
            if (lane_hit(5'(k), pend_addr_q, pend_size_q)) begin
                rd_pend[8*(5'(k - pend_addr_q) & 5'h03) +: 8] = img[k];
            end
        end
    end

    // a read fetch holds the bus, so nothing is taken during it
    assign take = i_sel && !ready_q && (state_q != ST_RSYNC) &&
                  (!needs_sync || state_q == ST_IDLE);
    assign done = (state_q != ST_IDLE) && cnt_rise &&
                  (edge_cnt_q == 2'(`TCS_SYNC_EDGES - 2'h1));

    // ****************************************************************
    // sync sequencer and bus answer
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        edge_cnt_d = edge_cnt_q;
        pend_addr_d = pend_addr_q;
        pend_size_d = pend_size_q;
        pend_wdata_d = pend_wdata_q;
        ready_d = 1'b0;
        rdata_d = rdata_q;
        if (take && !needs_sync) begin
            ready_d = 1'b1;
            if (!i_write) begin
                rdata_d = rd_now;
            end
        end
        unique case (state_q)
            ST_IDLE: begin
                if (take && needs_sync) begin
                    pend_addr_d = i_addr;
                    pend_size_d = i_size;
                    pend_wdata_d = i_wdata;
                    edge_cnt_d = 2'h0;
                    state_d = i_write ? ST_WSYNC : ST_RSYNC;
                    ready_d = i_write; // writes are posted
                end
            end
            ST_WSYNC, ST_RSYNC: begin
                if (done) begin
                    state_d = ST_IDLE;
                    if (state_q == ST_RSYNC) begin
                        ready_d = 1'b1;
                        rdata_d = rd_pend;
                    end
                end else if (cnt_rise) begin
                    edge_cnt_d = 2'(edge_cnt_q + 2'h1);
                end
            end
        endcase
        busy_d = (state_d != ST_IDLE);
        irq_d = |(flags_q & inten_q);
    end

    // ****************************************************************
    // register updates
    // ****************************************************************
    always_comb begin
        logic [7:0] wb;
        wb = 8'h00;
        soft_rst = 1'b0;
        ctrl_a_d = ctrl_a_q;
        rreq_d = rreq_q;
        event_d = event_q;
        ctrlb_d = ctrlb_q;
        control_c_d = control_c_q;
        debug_d = debug_q;
        inten_d = inten_q;
        flags_d = flags_q;
        count_d = count_q;
        period_d = period_q;
        cc0_d = cc0_q;
        cc1_d = cc1_q;
        for (int k = 0; k < 32; k++) begin
            if (take && i_write && lane_hit(5'(k), i_addr, i_size)) begin
                wb = lane_byte(5'(k), i_addr, i_wdata);
                unique case (5'(k))
                    `TCS_OFF_CTRL_A: if (!enabled) ctrl_a_d[7:2] = wb[7:2] & 6'(`TCS_MASK_CTRL_A >> 2);
                    `TCS_OFF_CTRL_A + 5'h01: if (!enabled) ctrl_a_d[15:8] = wb & 8'(`TCS_MASK_CTRL_A >> 8);
                    `TCS_OFF_READ_REQ: rreq_d[7:0] = wb & 8'(`TCS_MASK_READ_REQ);
                    `TCS_OFF_READ_REQ + 5'h01: rreq_d[15:8] = wb & 8'(`TCS_MASK_READ_REQ >> 8);
                    `TCS_OFF_DEBUG: debug_d = wb & `TCS_MASK_DEBUG;
                    `TCS_OFF_EVENT: event_d[7:0] = wb & 8'(`TCS_MASK_EVENT);
                    `TCS_OFF_EVENT + 5'h01: event_d[15:8] = wb & 8'(`TCS_MASK_EVENT >> 8);
                    `TCS_OFF_IEN_CLR: inten_d = inten_d & ~(wb & `TCS_MASK_FLAGS);
                    `TCS_OFF_IEN_SET: inten_d = inten_d | (wb & `TCS_MASK_FLAGS);
                    `TCS_OFF_FLAGS: flags_d = flags_d & ~(wb & `TCS_MASK_FLAGS);
                    default: ;
                endcase
            end
            // counter-side copies change only at the end of a write sync
            if (done && state_q == ST_WSYNC && lane_hit(5'(k), pend_addr_q, pend_size_q) &&
                sync_byte(5'(k), mode8, 1'b1)) begin
                wb = lane_byte(5'(k), pend_addr_q, pend_wdata_q);
                unique case (5'(k))
                    `TCS_OFF_CTRL_A: begin
                        soft_rst = wb[`TCS_BIT_SOFT_RESET_BIT];
                        ctrl_a_d[`TCS_BIT_ENABLE] = wb[`TCS_BIT_ENABLE];
                    end
                    `TCS_OFF_CTRLB_CLR: ctrlb_d = ctrlb_d & ~(wb & `TCS_MASK_CTRLB);
                    `TCS_OFF_CTRLB_SET: ctrlb_d = ctrlb_d | (wb & `TCS_MASK_CTRLB);
                    `TCS_OFF_CTRL_C: control_c_d = wb & `TCS_MASK_CTRL_C;
                    `TCS_OFF_COUNT: count_d[7:0] = wb;
                    `TCS_OFF_COUNT + 5'h01: count_d[15:8] = wb;
                    `TCS_OFF_PERIOD: period_d = wb;
                    `TCS_OFF_CC0: cc0_d[7:0] = wb;
                    `TCS_OFF_CC1_8: if (mode8) cc1_d[7:0] = wb; else cc0_d[15:8] = wb;
                    `TCS_OFF_CC1_16: cc1_d[7:0] = wb;
                    `TCS_OFF_CC1_16 + 5'h01: cc1_d[15:8] = wb;
                    default: ;
                endcase
            end
        end
        if (soft_rst) begin
            ctrl_a_d = `TCS_RST_HALF;
            rreq_d = `TCS_RST_HALF;
            event_d = `TCS_RST_HALF;
            ctrlb_d = `TCS_RST_BYTE;
            control_c_d = `TCS_RST_BYTE;
            debug_d = `TCS_RST_BYTE;
            inten_d = `TCS_RST_BYTE;
            flags_d = `TCS_RST_BYTE;
            count_d = `TCS_RST_HALF;
            period_d = `TCS_RST_BYTE;
            cc0_d = `TCS_RST_HALF;
            cc1_d = `TCS_RST_HALF;
        end
        // hardware sets win over a same-cycle software clear
        flags_d[`TCS_FLAG_OVF] = flags_d[`TCS_FLAG_OVF] | i_timer_events[0];
        flags_d[`TCS_FLAG_ERR] = flags_d[`TCS_FLAG_ERR] | i_timer_events[1];
        flags_d[`TCS_FLAG_MC0] = flags_d[`TCS_FLAG_MC0] | i_timer_events[2];
        flags_d[`TCS_FLAG_MC1] = flags_d[`TCS_FLAG_MC1] | i_timer_events[3];
        flags_d[`TCS_FLAG_SYNC] = flags_d[`TCS_FLAG_SYNC] | done;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            {ctrl_a_q, rreq_q, event_q, count_q, cc0_q, cc1_q} <= {6{`TCS_RST_HALF}};
            {ctrlb_q, control_c_q, debug_q, inten_q, flags_q, period_q} <= {6{`TCS_RST_BYTE}};
            state_q <= ST_IDLE;
            edge_cnt_q <= 2'h0;
            pend_addr_q <= 5'h00;
            pend_size_q <= SZ_BYTE;
            pend_wdata_q <= 32'h0000_0000;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            irq_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            {ctrl_a_q, rreq_q, event_q, count_q, cc0_q, cc1_q} <=
                {ctrl_a_d, rreq_d, event_d, count_d, cc0_d, cc1_d};
            {ctrlb_q, control_c_q, debug_q, inten_q, flags_q, period_q} <=
                {ctrlb_d, control_c_d, debug_d, inten_d, flags_d, period_d};
            state_q <= state_d;
            edge_cnt_q <= edge_cnt_d;
            pend_addr_q <= pend_addr_d;
            pend_size_q <= pend_size_d;
            pend_wdata_q <= pend_wdata_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            irq_q <= irq_d;
            busy_q <= busy_d;
        end
    end

    assign o_ready = ready_q;
    assign o_rdata = rdata_q;
    assign o_irq = irq_q;
    assign o_sync_pending = busy_q;
    assign o_enable = ctrl_a_q[`TCS_BIT_ENABLE];

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    a_commit_on_edge: assert property ($changed(count_q) && !$past(soft_rst) |-> $past(cnt_rise))
        else $error("count changed without a counter clock edge");
    a_busy_on_start: assert property (take && needs_sync |=> o_sync_pending)
        else $error("busy not raised at sync start");
    a_busy_hold_done: assert property (o_sync_pending && !done |=> o_sync_pending)
        else $error("busy dropped before sync finished");
    a_done_flag_set: assert property (done |=> flags_q[`TCS_FLAG_SYNC] && !o_sync_pending)
        else $error("sync done flag not set on completion");
    a_stall_busy: assert property (i_sel && needs_sync && o_sync_pending && !ready_q |-> !take)
        else $error("sync access taken while busy");
    a_read_completes: assert property (state_q == ST_RSYNC && done |=> o_ready && o_rdata == $past(rd_pend))
        else $error("stalled read not completed");
    a_enable_deferred: assert property (take && i_write && lane_hit(`TCS_OFF_CTRL_A, i_addr, i_size)
        |=> $stable(o_enable) ##1 $stable(o_enable))
        else $error("enable changed before synchronisation");
    a_count_deferred: assert property (take && i_write && lane_hit(`TCS_OFF_COUNT, i_addr, i_size)
        |=> $stable(count_q))
        else $error("count written without synchronisation");
    a_sync_read_wait: assert property (take && needs_sync && !i_write |=> !o_ready [*2])
        else $error("synchronised read answered at once");
    a_irq_follows: assert property (##1 o_irq == $past(|(flags_q & inten_q)))
        else $error("irq does not follow enabled flags");
    a_protect_ctrl: assert property (enabled && take && i_write |=> ctrl_a_q[15:2] == $past(ctrl_a_q[15:2]))
        else $error("protected control bits written while enabled");
    a_half_lanes: assert property (take && !i_write && i_addr == `TCS_OFF_EVENT && i_size == SZ_HALF
        |=> o_ready && o_rdata[15:0] == $past(event_q))
        else $error("half-word read lanes wrong");
    a_reserved_zero: assert property (take && !i_write && mode8 && i_addr == `TCS_OFF_COUNT + 5'h01 &&
        i_size == SZ_BYTE |=> o_ready && o_rdata == 32'h0000_0000)
        else $error("reserved offset read non-zero");

    c_write_sync: cover property (take && needs_sync && i_write ##[1:40] done);
    c_read_sync: cover property (take && needs_sync && !i_write ##[1:40] o_ready);
    c_stalled: cover property (i_sel && needs_sync && o_sync_pending ##[1:40] take);
    c_irq: cover property ($rose(o_irq));
endmodule : tcs_bank

// File: tb/tcs_host_model.sv
// bus master model driving the timer register bank
// assumes: shares the bus clock with the bank, one request at a time
`timescale 1ns/1ns
module tcs_host_model import tcs_pkg::*; (
    input wire logic i_clock,         // bus clock
    input wire logic i_ready,         // completion pulse
    input wire logic [31:0] i_rdata,  // read data
    output logic o_sel,               // request valid
    output logic o_write,             // 1 write
    output logic [4:0] o_addr,        // byte address
    output tcs_size_type o_size,      // access width
    output logic [31:0] o_wdata       // write data
);
    initial begin
        o_sel = 1'b0;
        o_write = 1'b0;
        o_addr = 5'h00;
        o_size = SZ_BYTE;
        o_wdata = 32'h0;
    end
    // ****************************************************************
    // one bus access, held until the completion pulse
    // ****************************************************************
    task automatic acc(input logic wr, input logic [4:0] a, input tcs_size_type sz,
                       input logic [31:0] wd, output logic [31:0] rd, output logic ok);
        int n;
        n = 0;
        @(posedge i_clock);
        o_sel <= 1'b1;
        o_write <= wr;
        o_addr <= a;
        o_size <= sz;
        o_wdata <= wd;
        do begin
            @(posedge i_clock);
            #1;
            n++;
        end while (!i_ready && n < 400);
        rd = i_rdata;
        // a missing completion pulse is reported, never taken as done
        ok = i_ready;
        @(posedge i_clock);
        o_sel <= 1'b0;
        // released address and data lines carry junk so stale data is never trusted
        o_addr <= ~a;
        o_wdata <= ~wd;
    endtask : acc
endmodule : tcs_host_model

// File: tb/timer_register_sync_bank_tb.sv
// self-checking bench for the timer register bank
// assumes: free-running counter clock slower than half the bus clock
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module timer_register_sync_bank_tb import tcs_pkg::*; ;
    logic clock = 1'b0;
    logic ctr_clk = 1'b0;
    logic reset = 1'b1;
    logic sel, wr_en, ready, irq, pend, enable;
    logic [4:0] addr;
    tcs_size_type size;
    logic [31:0] wdata, rdata, rd, d, d2;
    logic ok;
    logic [3:0] events = 4'h0;
    int n_errors = 0;
    int checks_done = 0;
    int seed = 32'h6f63;
    time t0;
    always #2 clock = ~clock;
    initial begin
        #3;
        forever #10 ctr_clk = ~ctr_clk;
    end
    tcs_bank DUT (.i_clock(clock), .i_reset(reset), .i_counter_clock(ctr_clk), .i_sel(sel),
        .i_write(wr_en), .i_addr(addr), .i_size(size), .i_wdata(wdata), .i_timer_events(events),
        .o_ready(ready), .o_rdata(rdata), .o_irq(irq), .o_sync_pending(pend), .o_enable(enable));
    tcs_host_model u_host (.i_clock(clock), .i_ready(ready), .i_rdata(rdata), .o_sel(sel),
        .o_write(wr_en), .o_addr(addr), .o_size(size), .o_wdata(wdata));
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] lane_mask(tcs_size_type sz);
        return (sz == SZ_BYTE) ? 32'h0000_00ff : (sz == SZ_HALF) ? 32'h0000_ffff : 32'hffff_ffff;
    endfunction : lane_mask
    task automatic wr(input logic [4:0] a, input tcs_size_type sz, input logic [31:0] v);
        u_host.acc(1'b1, a, sz, v & lane_mask(sz), rd, ok);
        `CHK(ok, 1'b1)
    endtask : wr
    task automatic rdchk(input logic [4:0] a, input tcs_size_type sz, input logic [31:0] e);
        u_host.acc(1'b0, a, sz, 32'h0, rd, ok);
        `CHK(ok, 1'b1)
        `CHK(rd & lane_mask(sz), e & lane_mask(sz))
    endtask : rdchk
    task automatic sync_wait();
        int n;
        n = 0;
        #1;
        `CHK(pend, 1'b1)
        while (pend === 1'b1 && n < 300) begin
            @(posedge clock);
            #1;
            n++;
        end
        `CHK(n < 300, 1'b1)
    endtask : sync_wait
    task automatic wrap_up();
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        rdchk(5'h0f, SZ_BYTE, 32'h08);
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            wr(5'h08, SZ_BYTE, d);
            rdchk(5'h08, SZ_BYTE, d & 32'h01);
            wr(5'h0a, SZ_HALF, d);
            rdchk(5'h0a, SZ_HALF, d & 32'h3137);
        end
        d = $random(seed);
        wr(5'h10, SZ_HALF, d);
        sync_wait();
        rdchk(5'h0e, SZ_BYTE, 32'h08);
        wr(5'h0e, SZ_BYTE, 32'h08);
        rdchk(5'h10, SZ_HALF, d);
        d = $random(seed);
        d2 = $random(seed);
        wr(5'h18, SZ_HALF, d);
        t0 = $time;
        // second sync write must wait for the first
        wr(5'h1a, SZ_HALF, d2);
        `CHK(($time - t0) > 20, 1'b1)
        sync_wait();
        rdchk(5'h18, SZ_HALF, d);
        rdchk(5'h1a, SZ_HALF, d2);
        wr(5'h14, SZ_BYTE, 32'hff);
        rdchk(5'h14, SZ_BYTE, 32'h0);
        wr(5'h00, SZ_BYTE, 32'h02);
        sync_wait();
        `CHK(enable, 1'b1)
        wr(5'h00, SZ_BYTE, 32'h06);
        sync_wait();
        rdchk(5'h00, SZ_BYTE, 32'h02);
        wr(5'h00, SZ_BYTE, 32'h04);
        sync_wait();
        `CHK(enable, 1'b0)
        // mode bits were refused while enabled; now disabled they take, 8-bit mode
        wr(5'h00, SZ_BYTE, 32'h04);
        sync_wait();
        rdchk(5'h00, SZ_BYTE, 32'h04);
        d = $random(seed);
        wr(5'h14, SZ_BYTE, d);
        sync_wait();
        rdchk(5'h14, SZ_BYTE, d);
        rdchk(5'h11, SZ_BYTE, 32'h0);
        wr(5'h0d, SZ_BYTE, 32'h01);
        @(posedge clock) events <= 4'h1;
        @(posedge clock) events <= 4'h0;
        repeat (2) @(posedge clock);
        #1;
        `CHK(irq, 1'b1)
        wr(5'h0e, SZ_BYTE, 32'h01);
        repeat (2) @(posedge clock);
        #1;
        `CHK(irq, 1'b0)
        wr(5'h00, SZ_BYTE, 32'h01);
        sync_wait();
        rdchk(5'h18, SZ_HALF, 32'h0);
        wrap_up();
    end
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end
endmodule : timer_register_sync_bank_tb
